/* File: sboe_host.sv */
`timescale 1ns/100ps
`default_nettype none
module sboe_host (
    input wire logic clk,
    output logic [19:0] shift_data,
    output logic load
);
    initial begin
        shift_data = 20'h0_0000;
        load = 1'b0;
    end

    // one-cycle load strobe, data scrambled after it
    task automatic put(input logic [19:0] v);
        @(posedge clk);
        shift_data <= v;
        load <= 1'b1;
        @(posedge clk);
        shift_data <= ~v;
        load <= 1'b0;
    endtask
endmodule // sboe_host
`default_nettype wire

/* File: sboe_pkg.sv */
// What this block does
// - side-band load copies shift register to readback
// - readback zero disables output unless masked
// - readback one needs enable bit, pin
// - enable pin gates only hundred mhz outputs
// - mask zero lets side-band disable output
// - mask one: only enable bit and pin disable
// - readback 0 and 1 read-only, reset ones
// - readback 2 bits 3:0, upper reserved zero
// - platform-time bypass bit rw, resets one
// - per-output mask bits rw, reset zero
`default_nettype none
package sboe_pkg;
    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [7:0] SBOE_ADDR_MASK0 = 8'h0b;
    localparam logic [7:0] SBOE_ADDR_MASK1 = 8'h0c;
    localparam logic [7:0] SBOE_ADDR_MASK2 = 8'h0d;
    localparam logic [7:0] SBOE_ADDR_RB_LO = 8'h0e;
    localparam logic [7:0] SBOE_ADDR_RB_MID = 8'h0f;
    localparam logic [7:0] SBOE_ADDR_RB_HI = 8'h10;
    localparam logic [7:0] SBOE_ADDR_PFT = 8'h31;
    // ----------------------------------------
    // widths and reset values
    // ----------------------------------------
    localparam int SBOE_NOUT = 20;
    localparam int SBOE_NFAST = 7;
    localparam logic [19:0] SBOE_RB_RST = 20'hf_ffff;
    localparam logic [19:0] SBOE_MASK_RST = 20'h0_0000;
    localparam logic [7:0] SBOE_PFT_RST = 8'h95;
    localparam logic [7:0] SBOE_PFT_WMASK = 8'h01;
    localparam logic [3:0] SBOE_HI_RSVD = 4'h0;
    // outputs with no enable pin (bits 19:7)
    localparam logic [19:0] SBOE_PIN_FREE = 20'hf_ff80;
endpackage
`default_nettype wire

/* File: sboe_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module sboe_properties
    import sboe_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [19:0] sideband_shift_data,
    input wire logic sideband_load,
    input wire logic [19:0] smb_oe_bits,
    input wire logic [6:0] fast_oe_n,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [19:0] out_enable,
    input wire logic platform_time_bypass
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    a_smb_gate: assert property (
        (out_enable & ~$past(smb_oe_bits)) == 20'h0_0000
    ) else $error("output enabled without its management bit");
    a_byp_wr: assert property (
        reg_wr && reg_addr == SBOE_ADDR_PFT |=> platform_time_bypass == $past(reg_wdata[0])
    ) else $error("bypass bit did not take the write");
    a_pin_gate: assert property (
        (out_enable[6:0] & $past(fast_oe_n)) == 7'h00
    ) else $error("hundred mhz output enabled with its pin high");
    a_pft_fixed: assert property (
        reg_addr == SBOE_ADDR_PFT |=> reg_rdata[7:1] == SBOE_PFT_RST[7:1]
    ) else $error("fixed bypass register bits changed");
    a_rsvd_zero: assert property (
        reg_addr == SBOE_ADDR_RB_HI |=> reg_rdata[7:4] == SBOE_HI_RSVD
    ) else $error("reserved readback bits not zero");
    a_load_view: assert property (
        sideband_load ##1 reg_addr == SBOE_ADDR_RB_LO |=> reg_rdata == $past(sideband_shift_data[7:0], 2)
    ) else $error("readback does not show loaded shift data");

    c_load_seen: cover property (sideband_load ##1 reg_addr == SBOE_ADDR_RB_LO);
    c_bypass_clear: cover property (reg_wr && reg_addr == SBOE_ADDR_PFT && !reg_wdata[0]);
    c_pin_off: cover property (fast_oe_n != 7'h00 && smb_oe_bits != 20'h0_0000);
endmodule // sboe_properties

bind sboe_top sboe_properties u_chk (
    .clk(clk),
    .nrst(nrst),
    .sideband_shift_data(sideband_shift_data),
    .sideband_load(sideband_load),
    .smb_oe_bits(smb_oe_bits),
    .fast_oe_n(fast_oe_n),
    .reg_wr(reg_wr),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .out_enable(out_enable),
    .platform_time_bypass(platform_time_bypass)
);
`default_nettype wire

/* File: sboe_top.sv */
`timescale 1ns/100ps
`default_nettype none
module sboe_top
    import sboe_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [19:0] sideband_shift_data,
    input wire logic sideband_load,
    input wire logic [19:0] smb_oe_bits,
    input wire logic [6:0] fast_oe_n,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic [19:0] out_enable,
    output logic platform_time_bypass
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [19:0] rb_ff;
    logic [19:0] nxt_rb;
    logic [19:0] mask_ff;
    logic [19:0] nxt_mask;
    logic [7:0] pft_ff;
    logic [7:0] nxt_pft;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic [19:0] en_ff;
    logic [19:0] nxt_en;

    // ----------------------------------------
    // decode and gating terms
    // ----------------------------------------
    logic wr_mask0;
    logic wr_mask1;
    logic wr_mask2;
    logic wr_pft;
    logic [6:0] rd_sel;
    logic [19:0] pin_ok;
    logic [19:0] sb_ok;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // write strobe aimed at one address
    function automatic logic wr_hit(
        input logic wr,
        input logic [7:0] addr,
        input logic [7:0] target
    );
        wr_hit = wr && (addr == target);
    endfunction

    // keep fixed bits, take writable ones
    function automatic logic [7:0] merge_wr(
        input logic [7:0] old,
        input logic [7:0] wd,
        input logic [7:0] wm
    );
        merge_wr = (old & ~wm) | (wd & wm);
    endfunction

    // third byte: reserved upper nibble
    function automatic logic [7:0] hi_byte(
        input logic [19:0] bits
    );
        hi_byte = {SBOE_HI_RSVD, bits[19:16]};
    endfunction

    // ----------------------------------------
    // write decode
    // ----------------------------------------
    // readback bytes have no write strobe
    always_comb begin
        wr_mask0 = wr_hit(reg_wr, reg_addr, SBOE_ADDR_MASK0);
        wr_mask1 = wr_hit(reg_wr, reg_addr, SBOE_ADDR_MASK1);
        wr_mask2 = wr_hit(reg_wr, reg_addr, SBOE_ADDR_MASK2);
        wr_pft = wr_hit(reg_wr, reg_addr, SBOE_ADDR_PFT);
    end

    // ----------------------------------------
    // read decode
    // ----------------------------------------
    always_comb begin
        rd_sel[0] = (reg_addr == SBOE_ADDR_MASK0);
        rd_sel[1] = (reg_addr == SBOE_ADDR_MASK1);
        rd_sel[2] = (reg_addr == SBOE_ADDR_MASK2);
        rd_sel[3] = (reg_addr == SBOE_ADDR_RB_LO);
        rd_sel[4] = (reg_addr == SBOE_ADDR_RB_MID);
        rd_sel[5] = (reg_addr == SBOE_ADDR_RB_HI);
        rd_sel[6] = (reg_addr == SBOE_ADDR_PFT);
    end

    // ----------------------------------------
    // side-band readback
    // ----------------------------------------
    always_comb begin
        nxt_rb = rb_ff;
        if (sideband_load) begin
            nxt_rb = sideband_shift_data;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rb_ff <= SBOE_RB_RST;
        end else begin
            rb_ff <= nxt_rb;
        end
    end

    // ----------------------------------------
    // side-band mask
    // ----------------------------------------
    always_comb begin
        nxt_mask = mask_ff;
        if (wr_mask0) begin
            nxt_mask[7:0] = reg_wdata;
        end
        if (wr_mask1) begin
            nxt_mask[15:8] = reg_wdata;
        end
        if (wr_mask2) begin
            nxt_mask[19:16] = reg_wdata[3:0];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mask_ff <= SBOE_MASK_RST;
        end else begin
            mask_ff <= nxt_mask;
        end
    end

    // ----------------------------------------
    // platform-time bypass
    // ----------------------------------------
    always_comb begin
        nxt_pft = pft_ff;
        if (wr_pft) begin
            nxt_pft = merge_wr(pft_ff, reg_wdata, SBOE_PFT_WMASK);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pft_ff <= SBOE_PFT_RST;
        end else begin
            pft_ff <= nxt_pft;
        end
    end

    // ----------------------------------------
    // read data
    // ----------------------------------------
    // unmapped addresses read zero
    always_comb begin
        nxt_rdata = 8'h00;
        if (rd_sel[0]) begin
            nxt_rdata = mask_ff[7:0];
        end else if (rd_sel[1]) begin
            nxt_rdata = mask_ff[15:8];
        end else if (rd_sel[2]) begin
            nxt_rdata = hi_byte(mask_ff);
        end else if (rd_sel[3]) begin
            nxt_rdata = rb_ff[7:0];
        end else if (rd_sel[4]) begin
            nxt_rdata = rb_ff[15:8];
        end else if (rd_sel[5]) begin
            nxt_rdata = hi_byte(rb_ff);
        end else if (rd_sel[6]) begin
            nxt_rdata = pft_ff;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ----------------------------------------
    // enable terms
    // ----------------------------------------
    always_comb begin
        // pin only on hundred mhz outputs
        pin_ok = SBOE_PIN_FREE | {13'h0000, ~fast_oe_n};
        // low readback disables unless guarded
        sb_ok = rb_ff | mask_ff;
    end

    // ----------------------------------------
    // effective enable
    // ----------------------------------------
    always_comb begin
        nxt_en = smb_oe_bits & pin_ok & sb_ok;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            en_ff <= 20'h0_0000;
        end else begin
            en_ff <= nxt_en;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign reg_rdata = rdata_ff;
    assign out_enable = en_ff;
    assign platform_time_bypass = pft_ff[0];

endmodule // sboe_top
`default_nettype wire

/* File: sideband_output_enable_readback_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module sideband_output_enable_readback_tb
    import sboe_pkg::*;
;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic reg_wr = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [19:0] smb_oe_bits = 20'hf_ffff;
    logic [6:0] fast_oe_n = 7'h00;
    logic [19:0] shift_data;
    logic sideband_load;
    logic [7:0] reg_rdata;
    logic [19:0] out_enable;
    logic platform_time_bypass;
    logic probe = 1'b0;
    logic [19:0] v;
    logic [19:0] rs;
    logic [6:0] rp;
    logic [19:0] exp_en;
    logic [28:0] q[$];
    int n_errors = 0;
    int compares = 0;
    int seed = 32'hf5d670c3;

    sboe_host h (
        .clk(clk),
        .shift_data(shift_data),
        .load(sideband_load)
    );

    sboe_top dut (
        .clk(clk),
        .nrst(nrst),
        .sideband_shift_data(shift_data),
        .sideband_load(sideband_load),
        .smb_oe_bits(smb_oe_bits),
        .fast_oe_n(fast_oe_n),
        .reg_wr(reg_wr),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .out_enable(out_enable),
        .platform_time_bypass(platform_time_bypass)
    );

    initial begin
        forever #12.5 clk = ~clk;
    end

    // ----------------------------------------
    // checking
    // ----------------------------------------
    task automatic summarize;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [28:0] seen, input logic [28:0] want);
        compares++;
        if (seen !== want) begin
            n_errors++;
            $display("mismatch %0t %h %h", $time, seen, want);
        end
    endtask

    always @(negedge clk) begin
        if (probe) begin
            chk({platform_time_bypass, out_enable, reg_rdata}, q.pop_front());
        end
    end

    // ----------------------------------------
    // register access
    // ----------------------------------------
    task automatic rd(input logic [7:0] addr, input logic [7:0] rdat, input logic [19:0] oe, input logic byp);
        @(posedge clk);
        reg_addr <= addr;
        @(posedge clk);
        probe <= 1'b1;
        q.push_back({byp, oe, rdat});
        @(posedge clk);
        probe <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= addr;
        reg_wdata <= data;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    initial begin
        repeat (1000) @(posedge clk);
        n_errors++;
        summarize;
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        rd(SBOE_ADDR_PFT, 8'h95, 20'hf_ffff, 1'b1);
        rd(SBOE_ADDR_RB_HI, 8'h0f, 20'hf_ffff, 1'b1);
        rd(SBOE_ADDR_MASK2, 8'h00, 20'hf_ffff, 1'b1);
        wr(SBOE_ADDR_PFT, 8'h00);
        rd(SBOE_ADDR_PFT, 8'h94, 20'hf_ffff, 1'b0);
        wr(SBOE_ADDR_PFT, 8'hff);
        rd(SBOE_ADDR_PFT, 8'h95, 20'hf_ffff, 1'b1);
        wr(SBOE_ADDR_RB_LO, 8'h00);
        rd(SBOE_ADDR_RB_LO, 8'hff, 20'hf_ffff, 1'b1);
        h.put(20'h0_0000);
        rd(SBOE_ADDR_RB_LO, 8'h00, 20'h0_0000, 1'b1);
        wr(SBOE_ADDR_MASK1, 8'hff);
        wr(SBOE_ADDR_MASK2, 8'hff);
        rd(SBOE_ADDR_MASK2, 8'h0f, 20'hf_ff00, 1'b1);
        repeat (6) begin
            v = 20'($random(seed));
            rs = 20'($random(seed));
            rp = 7'($random(seed));
            smb_oe_bits <= rs;
            fast_oe_n <= rp;
            exp_en = rs & (SBOE_PIN_FREE | {13'h0000, ~rp}) & (v | 20'hf_ff00);
            h.put(v);
            rd(SBOE_ADDR_RB_MID, v[15:8], exp_en, 1'b1);
            rd(SBOE_ADDR_RB_HI, {SBOE_HI_RSVD, v[19:16]}, exp_en, 1'b1);
        end
        summarize;
    end
endmodule // sideband_output_enable_readback_tb
`default_nettype wire
